// ### inc/ddcr_link_if.sv
// Purpose: link between the device register bank and its host end
// Assumes: both ends on clk; the data clock is a slow pin toward the device
// Notes: register port is one-cycle strobes, read data one cycle later
`timescale 1ns/1ns
`default_nettype none
interface ddcr_link_if;
  logic data_clock_input;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  modport dev (input data_clock_input, reg_addr, reg_wdata, reg_wr, reg_rd,
    output reg_rdata);
  modport host (output data_clock_input, reg_addr, reg_wdata, reg_wr, reg_rd,
    input reg_rdata);
endinterface
`default_nettype wire

// ### inc/ddcr_pkg.sv
// Purpose: shared constants for the data loop / clock receiver bank
// Assumes: 8-bit device registers, 32-bit AHB-Lite words on the host
// Notes: device offsets are byte offsets on the device register port
package ddcr_pkg;
  localparam int DDCR_CLK_NS = 100;
  localparam int DDCR_DCLK_NS = 800;
  localparam int DDCR_HALF_CYC = DDCR_DCLK_NS / (2 * DDCR_CLK_NS);
  localparam int DDCR_PRESENT_CYC = 16;
  localparam int DDCR_TAPS = 17;
  // device register offsets
  localparam logic [7:0] DDCR_OFS_LOOP_CTRL = 8'h0a;
  localparam logic [7:0] DDCR_OFS_WARN_CLR = 8'h0b;
  localparam logic [7:0] DDCR_OFS_TUNING = 8'h0c;
  localparam logic [7:0] DDCR_OFS_MODE_SEL = 8'h0d;
  localparam logic [7:0] DDCR_OFS_STATUS = 8'h0e;
  localparam logic [7:0] DDCR_OFS_SCLK_RX = 8'h10;
  localparam logic [7:0] DDCR_OFS_RCLK_RX = 8'h11;
  // device reset values
  localparam logic [7:0] DDCR_RST_LOOP_CTRL = 8'h40;
  localparam logic [7:0] DDCR_RST_WARN_CLR = 8'h39;
  localparam logic [7:0] DDCR_RST_TUNING = 8'h64;
  localparam logic [7:0] DDCR_RST_MODE_SEL = 8'h06;
  localparam logic [7:0] DDCR_RST_SCLK_RX = 8'hff;
  localparam logic [7:0] DDCR_RST_RCLK_RX = 8'h5f;
  // field positions
  localparam int DDCR_B_LOOP_EN = 7;
  localparam int DDCR_B_DUTY = 6;
  localparam int DDCR_B_SIGN = 3;
  localparam int DDCR_B_CLR_WARN = 7;
  localparam int DDCR_B_SLOW = 7;
  localparam int DDCR_B_DLMODE = 4;
  localparam int DDCR_B_LOCK = 7;
  localparam int DDCR_B_NEAR = 6;
  localparam int DDCR_B_START = 5;
  localparam int DDCR_B_END = 4;
  localparam int DDCR_B_PRESENT = 2;
  localparam int DDCR_B_TRACK = 0;
  localparam int DDCR_B_RX_DUTY = 7;
  localparam int DDCR_B_RX_CROSS = 5;
  localparam int DDCR_PHASE_MAX = 6;
  // host AHB-Lite word offsets
  localparam logic [7:0] DDCR_H_CMD = 8'h00;
  localparam logic [7:0] DDCR_H_STAT = 8'h04;
  localparam logic [7:0] DDCR_H_CTRL = 8'h08;
  localparam logic [7:0] DDCR_H_IRQ_STAT = 8'h0c;
  localparam logic [7:0] DDCR_H_IRQ_EN = 8'h10;
  localparam logic [7:0] DDCR_H_IRQ_CLR = 8'h14;
  localparam int DDCR_H_B_WRITE = 16;
  localparam int DDCR_EV_DONE = 0;
  localparam int DDCR_EV_REFUSED = 1;
  typedef enum logic [1:0] {
    DDCR_IDLE = 2'b00,
    DDCR_ISSUE = 2'b01,
    DDCR_WAIT = 2'b10
  } ddcr_state_type;
endpackage

// ### rtl/ddcr_device.sv
// Purpose: data capture loop and clock receiver register bank, device end
// Assumes: data clock much slower than clk; register strobes on clk
// Notes: the delay line is a tap counter standing in for the analog loop
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module ddcr_device import ddcr_pkg::*; #(
  parameter int TAPS = DDCR_TAPS,
  parameter int PRESENT_CYC = DDCR_PRESENT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  ddcr_link_if.dev link,
  output logic loop_enable,
  output logic data_duty_fix_on,
  output logic [3:0] phase_step,
  output logic slow_data_clock_select,
  output logic delay_line_mode_select,
  output logic sample_clock_duty_fix_on,
  output logic sample_clock_cross_ctrl_on,
  output logic [4:0] sample_clock_cross_level,
  output logic reference_duty_fix_on,
  output logic reference_cross_ctrl_on,
  output logic [4:0] reference_cross_level,
  output logic [$clog2(TAPS)-1:0] delay_tap,
  output logic loop_locked
);
  localparam int TW = $clog2(TAPS);
  localparam int MID = TAPS / 2;

  generate
    if (TAPS < 5 || TAPS > 64) begin : g_bad_taps
      $error("ddcr_device: TAPS must lie in 5..64");
    end
    if (PRESENT_CYC < 2 || PRESENT_CYC > 255) begin : g_bad_present
      $error("ddcr_device: PRESENT_CYC must lie in 2..255");
    end
  endgenerate

  logic [7:0] loop_ctrl_r, warn_clr_r, tuning_r, mode_sel_r, sclk_rx_r, rclk_rx_r;
  logic [7:0] rdata_r;
  logic [2:0] dclk_sync_r;
  logic [7:0] present_cnt_r;
  logic present_r, tracking_r, lock_r, near_r, start_r, end_r;
  logic [TW-1:0] tap_r;
  logic [TW-1:0] target;
  logic dclk_rise, wr_ctrl, clear_warn, track_nxt;
  logic [7:0] status;

  assign wr_ctrl = link.reg_wr;
  assign clear_warn = wr_ctrl && link.reg_addr == DDCR_OFS_WARN_CLR &&
    link.reg_wdata[DDCR_B_CLR_WARN];

  // register writes; reserved bits are stored as written
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loop_ctrl_r <= DDCR_RST_LOOP_CTRL;
      warn_clr_r <= DDCR_RST_WARN_CLR;
      tuning_r <= DDCR_RST_TUNING;
      mode_sel_r <= DDCR_RST_MODE_SEL;
      sclk_rx_r <= DDCR_RST_SCLK_RX;
      rclk_rx_r <= DDCR_RST_RCLK_RX;
    end else if (wr_ctrl) begin
      case (link.reg_addr)
        DDCR_OFS_LOOP_CTRL: loop_ctrl_r <= link.reg_wdata;
        DDCR_OFS_WARN_CLR: warn_clr_r <= link.reg_wdata;
        DDCR_OFS_TUNING: tuning_r <= link.reg_wdata;
        DDCR_OFS_MODE_SEL: mode_sel_r <= link.reg_wdata;
        DDCR_OFS_SCLK_RX: sclk_rx_r <= link.reg_wdata;
        DDCR_OFS_RCLK_RX: rclk_rx_r <= link.reg_wdata;
        default: ;
      endcase
    end
  end

  assign status = {lock_r, near_r, start_r, end_r, 1'b0, present_r, 1'b0, tracking_r};

  // read data stands from the edge after the read strobe until the next read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else if (link.reg_rd) begin
      case (link.reg_addr)
        DDCR_OFS_LOOP_CTRL: rdata_r <= loop_ctrl_r;
        DDCR_OFS_WARN_CLR: rdata_r <= warn_clr_r;
        DDCR_OFS_TUNING: rdata_r <= tuning_r;
        DDCR_OFS_MODE_SEL: rdata_r <= mode_sel_r;
        DDCR_OFS_STATUS: rdata_r <= status;
        DDCR_OFS_SCLK_RX: rdata_r <= sclk_rx_r;
        DDCR_OFS_RCLK_RX: rdata_r <= rclk_rx_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end
  assign link.reg_rdata = rdata_r;

  // data clock pin: two stages, then a third for the edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dclk_sync_r <= 3'h0;
    end else begin
      dclk_sync_r <= {dclk_sync_r[1:0], link.data_clock_input};
    end
  end
  assign dclk_rise = dclk_sync_r[1] && !dclk_sync_r[2];

  // presence: a rising edge seen within the last PRESENT_CYC cycles
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      present_cnt_r <= 8'h00;
      present_r <= 1'b0;
    end else if (dclk_rise) begin
      present_cnt_r <= 8'h00;
      present_r <= 1'b1;
    end else if (present_cnt_r == 8'(PRESENT_CYC - 1)) begin
      present_r <= 1'b0;
    end else begin
      present_cnt_r <= present_cnt_r + 8'h01;
    end
  end

  // lock target: mid line moved two taps per phase step, kept on the line
  always_comb begin
    int off;
    int pos;
    off = 2 * int'(loop_ctrl_r[2:0]);
    pos = loop_ctrl_r[DDCR_B_SIGN] ? MID - off : MID + off;
    if (pos < 0) begin
      pos = 0;
    end else if (pos > TAPS - 1) begin
      pos = TAPS - 1;
    end
    target = TW'(pos);
  end

  assign track_nxt = loop_ctrl_r[DDCR_B_LOOP_EN] && !mode_sel_r[DDCR_B_DLMODE];

  // closed loop walks one tap per data clock rising edge; otherwise held mid line
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tracking_r <= 1'b0;
      tap_r <= TW'(MID);
      lock_r <= 1'b0;
    end else begin
      tracking_r <= track_nxt;
      if (!track_nxt) begin
        tap_r <= TW'(MID);
      end else if (dclk_rise && tap_r < target) begin
        tap_r <= tap_r + TW'(1);
      end else if (dclk_rise && tap_r > target) begin
        tap_r <= tap_r - TW'(1);
      end
      lock_r <= tracking_r && present_r && tap_r == target;
    end
  end

  // sticky warnings; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      near_r <= 1'b0;
      start_r <= 1'b0;
      end_r <= 1'b0;
    end else begin
      if (tracking_r && (tap_r <= TW'(1) || tap_r >= TW'(TAPS - 2))) begin
        near_r <= 1'b1;
      end else if (clear_warn) begin
        near_r <= 1'b0;
      end
      if (tracking_r && tap_r == TW'(0)) begin
        start_r <= 1'b1;
      end else if (clear_warn) begin
        start_r <= 1'b0;
      end
      if (tracking_r && tap_r == TW'(TAPS - 1)) begin
        end_r <= 1'b1;
      end else if (clear_warn) begin
        end_r <= 1'b0;
      end
    end
  end

  assign loop_enable = loop_ctrl_r[DDCR_B_LOOP_EN];
  assign data_duty_fix_on = loop_ctrl_r[DDCR_B_DUTY];
  assign phase_step = loop_ctrl_r[3:0];
  assign slow_data_clock_select = mode_sel_r[DDCR_B_SLOW];
  assign delay_line_mode_select = mode_sel_r[DDCR_B_DLMODE];
  assign sample_clock_duty_fix_on = sclk_rx_r[DDCR_B_RX_DUTY];
  assign sample_clock_cross_ctrl_on = sclk_rx_r[DDCR_B_RX_CROSS];
  assign sample_clock_cross_level = sclk_rx_r[4:0];
  assign reference_duty_fix_on = rclk_rx_r[DDCR_B_RX_DUTY];
  assign reference_cross_ctrl_on = rclk_rx_r[DDCR_B_RX_CROSS];
  assign reference_cross_level = rclk_rx_r[4:0];
  assign delay_tap = tap_r;
  assign loop_locked = lock_r;
endmodule // ddcr_device
`default_nettype wire

// ### rtl/ddcr_host.sv
// Purpose: host end; AHB-Lite slave turning commands into register strobes
// Assumes: single word transfers, one outstanding device command
// Notes: a command written while busy is refused and flagged
`timescale 1ns/1ns
`default_nettype none
module ddcr_host import ddcr_pkg::*; #(
  parameter int HALF_CYC = DDCR_HALF_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq,
  ddcr_link_if.host link
);
  generate
    if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_bad_half
      $error("ddcr_host: HALF_CYC must lie in 1..255");
    end
  endgenerate

  logic [31:0] hrdata_r;
  logic wph_r;
  logic [7:0] waddr_r;
  logic [16:0] cmd_r;
  logic [7:0] rd_r;
  logic [2:0] ctrl_r;
  logic [1:0] ist_r, ien_r;
  logic irq_r;
  ddcr_state_type st_r;
  logic [7:0] addr_r, wdata_r;
  logic wr_r, rd_r_s;
  logic [7:0] div_r;
  logic dclk_r;
  logic [7:0] hreg;
  logic cmd_wr, busy, done_ev, refused_ev, clr_wr;
  logic [7:0] wdata_fix;

  assign hreg = haddr[7:0];
  assign busy = st_r != DDCR_IDLE;

  // address phase capture; reads answer with zero wait states
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wph_r <= 1'b0;
      waddr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else if (hready) begin
      wph_r <= hsel && htrans[1] && hwrite;
      waddr_r <= hreg;
      if (hsel && htrans[1] && !hwrite) begin
        case (hreg)
          DDCR_H_CMD: hrdata_r <= {15'h0000, cmd_r};
          DDCR_H_STAT: hrdata_r <= {16'h0000, rd_r, 7'h00, busy};
          DDCR_H_CTRL: hrdata_r <= {29'h0000_0000, ctrl_r};
          DDCR_H_IRQ_STAT: hrdata_r <= {30'h0000_0000, ist_r};
          DDCR_H_IRQ_EN: hrdata_r <= {30'h0000_0000, ien_r};
          default: hrdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign cmd_wr = wph_r && waddr_r == DDCR_H_CMD;
  assign clr_wr = wph_r && waddr_r == DDCR_H_IRQ_CLR;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= 3'h0;
      ien_r <= 2'h0;
    end else if (wph_r && waddr_r == DDCR_H_CTRL) begin
      ctrl_r <= hwdata[2:0];
    end else if (wph_r && waddr_r == DDCR_H_IRQ_EN) begin
      ien_r <= hwdata[1:0];
    end
  end

  // keep device-side settings legal before they go out
  always_comb begin
    wdata_fix = hwdata[15:8];
    case (hwdata[7:0])
      DDCR_OFS_LOOP_CTRL: begin
        if (hwdata[10:8] > 3'(DDCR_PHASE_MAX)) begin
          wdata_fix[2:0] = 3'(DDCR_PHASE_MAX);
        end
      end
      DDCR_OFS_WARN_CLR: wdata_fix[6:0] = DDCR_RST_WARN_CLR[6:0];
      DDCR_OFS_TUNING: wdata_fix = DDCR_RST_TUNING;
      DDCR_OFS_MODE_SEL: begin
        wdata_fix[3:0] = DDCR_RST_MODE_SEL[3:0];
        wdata_fix[DDCR_B_SLOW] = !ctrl_r[1];
        wdata_fix[DDCR_B_DLMODE] = !ctrl_r[2];
      end
      DDCR_OFS_SCLK_RX: wdata_fix[6] = DDCR_RST_SCLK_RX[6];
      DDCR_OFS_RCLK_RX: wdata_fix[6] = DDCR_RST_RCLK_RX[6];
      default: ;
    endcase
  end

  // command sequencer: issue one strobe, wait one cycle for read data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= DDCR_IDLE;
      cmd_r <= 17'h00000;
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r_s <= 1'b0;
      rd_r <= 8'h00;
    end else begin
      wr_r <= 1'b0;
      rd_r_s <= 1'b0;
      case (st_r)
        DDCR_IDLE: begin
          if (cmd_wr) begin
            cmd_r <= hwdata[16:0];
            addr_r <= hwdata[7:0];
            wdata_r <= wdata_fix;
            wr_r <= hwdata[DDCR_H_B_WRITE];
            rd_r_s <= !hwdata[DDCR_H_B_WRITE];
            st_r <= DDCR_ISSUE;
          end
        end
        DDCR_ISSUE: st_r <= DDCR_WAIT;
        DDCR_WAIT: begin
          if (!cmd_r[DDCR_H_B_WRITE]) begin
            rd_r <= link.reg_rdata;
          end
          st_r <= DDCR_IDLE;
        end
        default: st_r <= DDCR_IDLE;
      endcase
    end
  end
  assign done_ev = st_r == DDCR_WAIT;
  assign refused_ev = cmd_wr && busy;
  assign link.reg_addr = addr_r;
  assign link.reg_wdata = wdata_r;
  assign link.reg_wr = wr_r;
  assign link.reg_rd = rd_r_s;

  // sticky events; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ist_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      ist_r[DDCR_EV_DONE] <= done_ev ||
        (ist_r[DDCR_EV_DONE] && !(clr_wr && hwdata[DDCR_EV_DONE]));
      ist_r[DDCR_EV_REFUSED] <= refused_ev ||
        (ist_r[DDCR_EV_REFUSED] && !(clr_wr && hwdata[DDCR_EV_REFUSED]));
      irq_r <= |(ist_r & ien_r);
    end
  end
  assign irq = irq_r;

  // data clock divider, runs while the enable bit is set
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= 8'h00;
      dclk_r <= 1'b0;
    end else if (!ctrl_r[0]) begin
      div_r <= 8'h00;
      dclk_r <= 1'b0;
    end else if (div_r == 8'(HALF_CYC - 1)) begin
      div_r <= 8'h00;
      dclk_r <= !dclk_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end
  assign link.data_clock_input = dclk_r;
endmodule // ddcr_host
`default_nettype wire

// ### sim/ddcr_asserts.sv
// Purpose: interface checker for the device register port of the loop/receiver bank
// Assumes: both ends on clk; status reads answer one cycle after the strobe
// Notes: shadows track what was written so readback and status bits can be tied to it
`timescale 1ns/1ns
`default_nettype none
module ddcr_asserts import ddcr_pkg::*; #(
  parameter int PRESENT_CYC = DDCR_PRESENT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic data_clock_input,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  logic [7:0] sh_a_r, sh_d_r, sh_s_r, sh_f_r, gap_r;
  logic clk_prev_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sh_a_r <= 8'h40;
      sh_d_r <= 8'h06;
      sh_s_r <= 8'hff;
      sh_f_r <= 8'h5f;
    end else if (reg_wr) begin
      if (reg_addr == 8'h0a) sh_a_r <= reg_wdata;
      if (reg_addr == 8'h0d) sh_d_r <= reg_wdata;
      if (reg_addr == 8'h10) sh_s_r <= reg_wdata;
      if (reg_addr == 8'h11) sh_f_r <= reg_wdata;
    end
  end
  // cycles since the last data clock rise, saturating so a dead clock reads as long ago
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_r <= 8'hff;
      clk_prev_r <= 1'b0;
    end else begin
      clk_prev_r <= data_clock_input;
      if (data_clock_input && !clk_prev_r) gap_r <= 8'h00;
      else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
    end
  end
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read strobe");
  a_reserved_zero: assert property (reg_rd && reg_addr == 8'h0e |=> !reg_rdata[3] && !reg_rdata[1])
    else $error("reserved status bits read non-zero");
  a_near_covers_ends: assert property (reg_rd && reg_addr == 8'h0e ##1 (reg_rdata[5] || reg_rdata[4]) |-> reg_rdata[6])
    else $error("end flag without near flag");
  a_lock_needs_track: assert property (reg_rd && reg_addr == 8'h0e ##1 reg_rdata[7] |-> reg_rdata[0] && reg_rdata[2])
    else $error("lock shown without tracking and clock");
  a_track_mode: assert property (reg_rd && reg_addr == 8'h0e |=> reg_rdata[0] == (sh_a_r[7] && !sh_d_r[4]))
    else $error("tracking bit disagrees with mode bits");
  a_loop_readback: assert property (reg_rd && reg_addr == 8'h0a |=> {reg_rdata[7:6], reg_rdata[3:0]} == {sh_a_r[7:6], sh_a_r[3:0]})
    else $error("loop control readback wrong");
  a_sample_readback: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata == sh_s_r)
    else $error("sample clock receiver readback wrong");
  a_ref_readback: assert property (reg_rd && reg_addr == 8'h11 |=> reg_rdata == sh_f_r)
    else $error("reference receiver readback wrong");
  a_clock_seen: assert property (reg_rd && reg_addr == 8'h0e && gap_r >= 8'd4 && gap_r <= 8'd10 |=> reg_rdata[2])
    else $error("running data clock not reported present");
  a_clock_gone: assert property (reg_rd && reg_addr == 8'h0e && gap_r > PRESENT_CYC + 8 |=> !reg_rdata[2])
    else $error("stopped data clock still reported present");
endmodule // ddcr_asserts
`default_nettype wire

// ### sim/ddcr_tb.sv
// Purpose: self-checking bench joining host and device ends over the link
// Assumes: zero-wait AHB-Lite slave; host forces reserved fields and clamps phase
// Notes: table rows hold address, written byte and expected readback
`timescale 1ns/1ns
`default_nettype none
module ddcr_tb import ddcr_pkg::*;;
  logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, s;
  logic [1:0] htrans = 2'b00;
  logic hreadyout, hresp, irq;
  logic [7:0] q;
  int mismatches = 0, check_count = 0;
  logic [27:0] dev_o;
  logic [23:0] rows [11] = '{24'h0ac5c5, 24'h0a0706, 24'h0a0f0e, 24'h104040, 24'h102f6f,
    24'h11bfff, 24'h110040, 24'h0c0064, 24'h0b80b9, 24'h0d0006, 24'h0f5500};
  logic [15:0] rst_vals [6] = '{16'h0a40, 16'h0b39, 16'h0c64, 16'h0d06, 16'h10ff, 16'h115f};
  ddcr_link_if lnk();
  ddcr_host u_ddcr_host (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq), .link(lnk));
  ddcr_device u_ddcr_device (.clk(clk), .nrst(nrst), .link(lnk), .loop_enable(dev_o[27]),
    .data_duty_fix_on(dev_o[26]), .phase_step(dev_o[25:22]),
    .slow_data_clock_select(dev_o[21]), .delay_line_mode_select(dev_o[20]),
    .sample_clock_duty_fix_on(dev_o[19]), .sample_clock_cross_ctrl_on(dev_o[18]),
    .sample_clock_cross_level(dev_o[17:13]), .reference_duty_fix_on(dev_o[12]),
    .reference_cross_ctrl_on(dev_o[11]), .reference_cross_level(dev_o[10:6]),
    .delay_tap(dev_o[5:1]), .loop_locked(dev_o[0]));
  ddcr_asserts u_ddcr_asserts (.clk(clk), .nrst(nrst), .data_clock_input(lnk.data_clock_input),
    .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata), .reg_wr(lnk.reg_wr),
    .reg_rd(lnk.reg_rd), .reg_rdata(lnk.reg_rdata));
  always #50 clk = ~clk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r);
    // called right after an edge; no spare cycle, so a second command can land while busy
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsel <= 1'b1;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  // waits for the done event rather than a cycle count, then clears it
  task automatic dev_op(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] r);
    logic [31:0] v;
    int k;
    ahb(DDCR_H_CMD, 1'b1, {15'h0, w, d, a}, v);
    v = 32'h0;
    k = 0;
    while (v[0] !== 1'b1 && k < 40) begin
      ahb(DDCR_H_IRQ_STAT, 1'b0, 32'h0, v);
      k++;
    end
    chk("done", 32'h1, {31'h0, v[0]});
    ahb(DDCR_H_IRQ_CLR, 1'b1, 32'h1, v);
    ahb(DDCR_H_STAT, 1'b0, 32'h0, v);
    r = v[15:8];
  endtask
  task automatic status(input logic [7:0] e);
    dev_op(1'b0, 8'h0e, 8'h00, q);
    chk("status", {24'h0, e}, {24'h0, q});
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    ahb(DDCR_H_CTRL, 1'b1, 32'h7, s);
    foreach (rows[i]) begin
      dev_op(1'b1, rows[i][23:16], rows[i][15:8], q);
      dev_op(1'b0, rows[i][23:16], 8'h00, q);
      chk("readback", {24'h0, rows[i][7:0]}, {24'h0, q});
    end
    ahb(8'h1c, 1'b0, 32'h0, s);
    chk("unmapped", 32'h0, s);
    chk("hresp", 32'h0, {31'h0, hresp});
    // second reset in mid-run must bring every device register back
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    foreach (rst_vals[i]) begin
      dev_op(1'b0, rst_vals[i][15:8], 8'h00, q);
      chk("reset", {24'h0, rst_vals[i][7:0]}, {24'h0, q});
    end
    chk("reset_pins", 32'h040fe7d0, {4'h0, dev_o});
    status(8'h00);
    ahb(DDCR_H_CTRL, 1'b1, 32'h7, s);
    dev_op(1'b1, 8'h0d, 8'h00, q);
    dev_op(1'b1, 8'h0a, 8'h80, q);
    repeat (100) @(posedge clk);
    status(8'h85);
    dev_op(1'b1, 8'h0a, 8'h86, q);
    repeat (200) @(posedge clk);
    status(8'hd5);
    chk("tap_lock_pins", 32'h9a1, {20'h0, dev_o[27:22], dev_o[5:0]});
    dev_op(1'b1, 8'h0a, 8'h8e, q);
    repeat (250) @(posedge clk);
    status(8'hf5);
    ahb(DDCR_H_CTRL, 1'b1, 32'h1, s);
    dev_op(1'b1, 8'h0d, 8'h00, q);
    repeat (20) @(posedge clk);
    status(8'h74);
    chk("mode_pins", 32'h3, {30'h0, dev_o[21:20]});
    dev_op(1'b1, 8'h0b, 8'h80, q);
    status(8'h04);
    ahb(DDCR_H_CTRL, 1'b1, 32'h0, s);
    repeat (60) @(posedge clk);
    status(8'h00);
    // a command while busy is refused; interrupt stays masked until enabled
    ahb(DDCR_H_CMD, 1'b1, 32'h0000000a, s);
    ahb(DDCR_H_CMD, 1'b1, 32'h0000000a, s);
    repeat (10) @(posedge clk);
    ahb(DDCR_H_IRQ_STAT, 1'b0, 32'h0, s);
    chk("irq_status", 32'h3, s);
    chk("irq_masked", 32'h0, {31'h0, irq});
    ahb(DDCR_H_IRQ_EN, 1'b1, 32'h2, s);
    ahb(DDCR_H_IRQ_STAT, 1'b0, 32'h0, s);
    chk("irq_on", 32'h1, {31'h0, irq});
    ahb(DDCR_H_IRQ_CLR, 1'b1, 32'h3, s);
    ahb(DDCR_H_IRQ_STAT, 1'b0, 32'h0, s);
    chk("irq_cleared", 32'h0, {s[30:0], irq});
    conclude();
  end
endmodule // ddcr_tb
`default_nettype wire
